// File: cfs_pkg.sv
package cfs_pkg;
  // condition flag bit positions
  localparam int CF_CARRY = 0;
  localparam int CF_ZERO = 1;
  localparam int CF_NEG = 2;
  localparam int CF_PLOW = 3;
  localparam int CF_HALF = 4;
  localparam int CF_PHIGH = 5;
  localparam logic [7:0] CF_RESET = 8'he8;
  localparam logic [7:0] CF_UNUSED_MASK = 8'hc0;
  localparam logic [7:0] SP_HIGH = 8'h01;
  localparam logic [7:0] SP_LOW_RESET = 8'hff;
  localparam logic [15:0] SP_RESET = 16'h01ff;
  localparam logic [1:0] PRIO_MAIN = 2'b10;
  localparam logic [1:0] PRIO_DISABLE = 2'b11;
  localparam logic [2:0] CTX_BYTES = 3'h5;
  localparam logic [2:0] CALL_BYTES = 3'h2;

  typedef enum logic [3:0] {
    CFS_OP_NONE = 4'h0,
    CFS_OP_ALU = 4'h1,
    CFS_OP_SET_CARRY = 4'h2,
    CFS_OP_CLR_CARRY = 4'h3,
    CFS_OP_CARRY_ONLY = 4'h4,
    CFS_OP_PRIO_LOAD = 4'h5,
    CFS_OP_PUSH = 4'h6,
    CFS_OP_POP = 4'h7,
    CFS_OP_SP_RESET = 4'h8,
    CFS_OP_SP_LOAD = 4'h9,
    CFS_OP_IRQ_ENTRY = 4'ha,
    CFS_OP_IRQ_RETURN = 4'hb,
    CFS_OP_CALL = 4'hc,
    CFS_OP_RETURN = 4'hd,
    CFS_OP_FLAGS_LOAD = 4'he
  } cfs_op_type;

  typedef enum logic [2:0] {
    CFS_IDLE = 3'b000,
    CFS_CTX_PCL = 3'b001,
    CFS_CTX_PCH = 3'b010,
    CFS_CTX_X = 3'b011,
    CFS_CTX_ACC = 3'b100,
    CFS_CTX_FLAGS = 3'b101
  } cfs_state_type;

  typedef struct packed {
    logic [7:0] result;
    logic carry;
    logic half;
    logic is_add;
    logic carry_valid;
  } cfs_alu_type;

  typedef struct packed {
    logic [7:0] prog_counter_low;
    logic [7:0] pch;
    logic [7:0] x;
    logic [7:0] acc;
  } cfs_ctx_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] data;
  } cfs_stack_type;
endpackage : cfs_pkg

// File: cfs_sp_step.sv
`timescale 1ns/100ps
// next stack pointer low byte for one push or pop step
module cfs_sp_step (
  input wire logic [7:0] low, // current low byte
  input wire logic dec, // step down
  input wire logic inc, // step up
  output logic [7:0] next_low // stepped low byte
);
  import cfs_pkg::*;
  always_comb begin
    next_low = low;
    if (dec) begin
      next_low = low - 8'h01; // see (RULE14)
    end else if (inc) begin
      next_low = low + 8'h01; // see (RULE14)
    end
  end
endmodule : cfs_sp_step

// File: cfs_flag_calc.sv
`timescale 1ns/100ps
// flag values from one alu result
module cfs_flag_calc (
  input cfs_pkg::cfs_alu_type alu, // alu outcome
  input wire logic [7:0] flags, // current flags
  output logic [7:0] next_flags // updated flags
);
  import cfs_pkg::*;
  always_comb begin
    next_flags = flags;
    next_flags[CF_NEG] = alu.result[7]; // see (RULE3)
    next_flags[CF_ZERO] = (alu.result == 8'h00); // see (RULE4)
    if (alu.is_add) begin
      next_flags[CF_HALF] = alu.half; // see (RULE2)
    end
    if (alu.carry_valid) begin
      next_flags[CF_CARRY] = alu.carry; // see (RULE5)
    end
  end
endmodule : cfs_flag_calc

// File: cfs_core.sv
`timescale 1ns/100ps
// Functional notes
// (RULE1) eight-bit flags: priority pair, four result flags
// (RULE2) half carry from bit three on adds
// (RULE3) negative flag copies result bit seven
// (RULE4) zero flag set on zero result
// (RULE5) carry from arithmetic, forced, shift, bit-test
// (RULE6) priority code 10,01,00,11 for levels 0-3
// (RULE7) interrupt entry loads source priority
// (RULE8) instructions may rewrite priority field
// (RULE9) flags pushable, poppable, individually loadable
// (RULE10) pointer decrements after push, increments before pop
// (RULE11) pointer high byte fixed by hardware
// (RULE12) reset or stack-reset gives 01ff
// (RULE13) low byte loadable and readable
// (RULE14) pointer wraps silently both ways
// (RULE15) interrupt pushes low pc first
// (RULE16) call two bytes, interrupt five bytes
// (RULE17) index Y never stacked by interrupts
// (RULE18) context order pcl, pch, x, acc, flags
module cfs_core (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input cfs_pkg::cfs_op_type op, // operation request, one cycle
  input cfs_pkg::cfs_alu_type alu, // alu outcome for alu ops
  input wire logic [7:0] wr_data, // load or pop data
  input wire logic [1:0] src_priority, // priority of entering source
  input cfs_pkg::cfs_ctx_type ctx, // context to save on entry
  output logic [7:0] condition_flags, // flags register
  output logic [15:0] stack_pointer, // stack pointer
  output logic [1:0] priority_level, // current level 0-3
  output logic irq_disabled, // level 3 reached
  output cfs_pkg::cfs_stack_type stack_bus, // stack memory access
  output cfs_pkg::cfs_ctx_type ctx_restored, // context popped on return
  output logic ctx_valid, // one cycle: ctx_restored ready
  output logic busy // sequence in progress
);
  import cfs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state
  cfs_state_type state;
  cfs_state_type next_state;
  logic restoring;
  logic next_restoring;

  logic [7:0] flags;
  logic [7:0] next_flags;
  logic [7:0] sp_low;
  logic [7:0] next_sp_low;

  // context saved on entry and restored on return
  cfs_ctx_type saved;
  cfs_ctx_type next_saved;
  cfs_stack_type next_stack_bus;
  cfs_ctx_type next_ctx_restored;
  logic next_ctx_valid;

  // helper results
  logic [7:0] alu_flags;
  logic [7:0] stepped_low;
  logic step_dec;
  logic step_inc;
  logic [7:0] pop_low;

  // return address bytes still to move
  logic [1:0] call_left;
  logic [1:0] next_call_left;
  logic call_pop;
  logic next_call_pop;

  // next output register values
  logic [1:0] next_priority_level;
  logic [15:0] next_stack_pointer;
  logic next_irq_disabled;
  logic next_busy;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  cfs_flag_calc u_flag_calc (
    .alu(alu),
    .flags(flags),
    .next_flags(alu_flags)
  );

  cfs_sp_step u_sp_step (
    .low(sp_low),
    .dec(step_dec),
    .inc(step_inc),
    .next_low(stepped_low)
  );

  // pop pre-increments, so the byte read sits one above the pointer
  assign pop_low = sp_low + 8'h01; // see (RULE10)

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_state = state;
    next_restoring = restoring;
    next_flags = flags;
    next_saved = saved;
    next_sp_low = sp_low;
    next_stack_bus = '0;
    next_ctx_restored = ctx_restored;
    next_ctx_valid = 1'b0;
    next_call_left = call_left;
    next_call_pop = call_pop;
    step_dec = 1'b0;
    step_inc = 1'b0;
    case (state)
      CFS_IDLE: begin
        if (call_left != 2'b00) begin
          // return address: two bytes per call or return
          next_stack_bus.valid = 1'b1; // see (RULE16)
          next_stack_bus.write = !call_pop;
          next_stack_bus.addr = {SP_HIGH, call_pop ? pop_low : sp_low};
          next_stack_bus.data = (call_left == 2'b10) ? ctx.prog_counter_low : ctx.pch;
          step_dec = !call_pop;
          step_inc = call_pop;
          next_sp_low = stepped_low;
          next_call_left = call_left - 2'b01;
        end else begin
          case (op)
            CFS_OP_ALU: begin
              next_flags = alu_flags;
            end
            CFS_OP_SET_CARRY: begin
              next_flags[CF_CARRY] = 1'b1; // see (RULE5)
            end
            CFS_OP_CLR_CARRY: begin
              next_flags[CF_CARRY] = 1'b0; // see (RULE5)
            end
            CFS_OP_CARRY_ONLY: begin
              next_flags[CF_CARRY] = alu.carry; // see (RULE5)
            end
            CFS_OP_PRIO_LOAD: begin
              next_flags[CF_PHIGH] = wr_data[1]; // see (RULE8)
              next_flags[CF_PLOW] = wr_data[0]; // see (RULE8)
            end
            CFS_OP_FLAGS_LOAD: begin
              next_flags = wr_data | CF_UNUSED_MASK; // see (RULE9)
            end
            CFS_OP_PUSH: begin
              // push of the flags register
              next_stack_bus.valid = 1'b1; // see (RULE9)
              next_stack_bus.write = 1'b1;
              next_stack_bus.addr = {SP_HIGH, sp_low};
              next_stack_bus.data = flags;
              step_dec = 1'b1; // see (RULE10)
              next_sp_low = stepped_low;
            end
            CFS_OP_POP: begin
              next_stack_bus.valid = 1'b1; // see (RULE9)
              next_stack_bus.addr = {SP_HIGH, pop_low};
              next_flags = wr_data | CF_UNUSED_MASK; // see (RULE8)
              step_inc = 1'b1; // see (RULE10)
              next_sp_low = stepped_low;
            end
            CFS_OP_SP_RESET: begin
              next_sp_low = SP_LOW_RESET; // see (RULE12)
            end
            CFS_OP_SP_LOAD: begin
              next_sp_low = wr_data; // see (RULE13)
            end
            CFS_OP_CALL: begin
              // bytes move one per cycle from the next cycle on
              next_call_left = CALL_BYTES[1:0]; // see (RULE16)
              next_call_pop = 1'b0;
            end
            CFS_OP_RETURN: begin
              next_call_left = CALL_BYTES[1:0]; // see (RULE16)
              next_call_pop = 1'b1;
            end
            CFS_OP_IRQ_ENTRY: begin
              // Y is not part of the saved context
              next_saved = ctx; // see (RULE17)
              next_restoring = 1'b0;
              next_state = CFS_CTX_PCL; // see (RULE15)
            end
            CFS_OP_IRQ_RETURN: begin
              // pops start with the flags, the last byte pushed
              next_restoring = 1'b1;
              next_state = CFS_CTX_FLAGS; // see (RULE18)
            end
            default: begin
              next_flags = flags;
            end
          endcase
        end
      end
      default: begin
        // ops seen while a context sequence runs are dropped
        next_stack_bus.valid = 1'b1;
        next_stack_bus.write = !restoring;
        next_stack_bus.addr = {SP_HIGH, restoring ? pop_low : sp_low};
        step_dec = !restoring; // see (RULE15)
        step_inc = restoring; // see (RULE15)
        next_sp_low = stepped_low;
        case (state)
          CFS_CTX_PCL: begin
            next_stack_bus.data = saved.prog_counter_low; // see (RULE15)
            next_ctx_restored.prog_counter_low = wr_data;
            next_state = restoring ? CFS_IDLE : CFS_CTX_PCH;
            // last pop on return: the whole context is restored
            next_ctx_valid = restoring;
          end
          CFS_CTX_PCH: begin
            next_stack_bus.data = saved.pch; // see (RULE18)
            next_ctx_restored.pch = wr_data;
            next_state = restoring ? CFS_CTX_PCL : CFS_CTX_X;
          end
          CFS_CTX_X: begin
            next_stack_bus.data = saved.x; // see (RULE18)
            next_ctx_restored.x = wr_data;
            next_state = restoring ? CFS_CTX_PCH : CFS_CTX_ACC;
          end
          CFS_CTX_ACC: begin
            next_stack_bus.data = saved.acc; // see (RULE18)
            next_ctx_restored.acc = wr_data;
            next_state = restoring ? CFS_CTX_X : CFS_CTX_FLAGS;
          end
          CFS_CTX_FLAGS: begin
            next_stack_bus.data = flags; // see (RULE18)
            if (restoring) begin
              next_flags = wr_data | CF_UNUSED_MASK; // see (RULE8)
              next_state = CFS_CTX_ACC;
            end else begin
              // priority of the entering source after flags are saved
              next_flags[CF_PHIGH] = src_priority[1]; // see (RULE7)
              next_flags[CF_PLOW] = src_priority[0]; // see (RULE7)
              next_state = CFS_IDLE;
            end
          end
          default: begin
            next_state = CFS_IDLE;
          end
        endcase
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= CFS_IDLE;
      restoring <= 1'b0;
      flags <= CF_RESET; // see (RULE1)
      sp_low <= SP_LOW_RESET; // see (RULE12)
      saved <= '0;
      stack_bus <= '0;
      ctx_restored <= '0;
      ctx_valid <= 1'b0;
      call_left <= 2'b00;
      call_pop <= 1'b0;
    end else begin
      state <= next_state;
      restoring <= next_restoring;
      flags <= next_flags;
      sp_low <= next_sp_low;
      saved <= next_saved;
      stack_bus <= next_stack_bus;
      ctx_restored <= next_ctx_restored;
      ctx_valid <= next_ctx_valid;
      call_left <= next_call_left;
      call_pop <= next_call_pop;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output registers
  always_comb begin
    next_stack_pointer = {SP_HIGH, next_sp_low}; // see (RULE11)
    // the level decode follows the flags of the same cycle
    next_priority_level = 2'b00;
    case ({next_flags[CF_PHIGH], next_flags[CF_PLOW]})
      2'b10: next_priority_level = 2'd0; // see (RULE6)
      2'b01: next_priority_level = 2'd1; // see (RULE6)
      2'b00: next_priority_level = 2'd2; // see (RULE6)
      default: next_priority_level = 2'd3; // see (RULE6)
    endcase
    next_irq_disabled = (next_priority_level == 2'd3);
    // busy covers the context sequence and pending call bytes
    next_busy = (next_state != CFS_IDLE) || (next_call_left != 2'b00);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // level 3 out of reset: interrupts stay masked
      condition_flags <= CF_RESET; // see (RULE1)
      stack_pointer <= SP_RESET; // see (RULE12)
      priority_level <= 2'd3;
      irq_disabled <= 1'b1;
      busy <= 1'b0;
    end else begin
      condition_flags <= next_flags;
      stack_pointer <= next_stack_pointer;
      priority_level <= next_priority_level;
      irq_disabled <= next_irq_disabled;
      busy <= next_busy;
    end
  end
endmodule : cfs_core

// File: cfs_core_props.sv
`timescale 1ns/100ps
module cfs_core_props
  import cfs_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst_n, // reset, active low
  input cfs_pkg::cfs_op_type op, // request
  input cfs_pkg::cfs_alu_type alu, // alu outcome
  input wire logic [7:0] wr_data, // load data
  input cfs_pkg::cfs_ctx_type ctx, // context in
  input wire logic [7:0] condition_flags, // flags
  input wire logic [15:0] stack_pointer, // pointer
  input wire logic irq_disabled, // level 3
  input cfs_pkg::cfs_stack_type stack_bus, // stack access
  input wire logic ctx_valid, // return done
  input wire logic busy // sequence running
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  sp_high_fixed_a: assert property (
    stack_pointer[15:8] == SP_HIGH)
    else $error("pointer high byte changed");
  alu_nz_a: assert property (!busy && op == CFS_OP_ALU |=>
    condition_flags[CF_NEG] == $past(alu.result[7]) &&
    condition_flags[CF_ZERO] == ($past(alu.result) == 8'h00))
    else $error("negative or zero flag wrong");
  half_carry_a: assert property (
    !busy && op == CFS_OP_ALU && alu.is_add
    |=> condition_flags[CF_HALF] == $past(alu.half))
    else $error("half carry wrong");
  carry_force_a: assert property (!busy && op == CFS_OP_SET_CARRY
    |=> condition_flags[CF_CARRY])
    else $error("carry not set");
  push_step_a: assert property (
    !busy && op == CFS_OP_PUSH |=>
    stack_bus.valid && stack_bus.write &&
    stack_bus.addr == $past(stack_pointer) &&
    stack_pointer[7:0] == $past(stack_pointer[7:0]) - 8'h01)
    else $error("push step wrong");
  pop_step_a: assert property (!busy && op == CFS_OP_POP
    |=> stack_pointer[7:0] == $past(stack_pointer[7:0]) + 8'h01)
    else $error("pop step wrong");
  sp_load_a: assert property (!busy && op == CFS_OP_SP_LOAD
    |=> stack_pointer == {SP_HIGH, $past(wr_data)})
    else $error("pointer load wrong");
  sp_reset_op_a: assert property (!busy && op == CFS_OP_SP_RESET
    |=> stack_pointer == SP_RESET)
    else $error("stack reset wrong");
  entry_first_a: assert property (
    !busy && op == CFS_OP_IRQ_ENTRY |-> ##2
    stack_bus.write && stack_bus.data == $past(ctx.prog_counter_low, 2) &&
    stack_bus.addr == $past(stack_pointer, 2))
    else $error("entry first byte wrong");
  entry_count_a: assert property (!busy && op == CFS_OP_IRQ_ENTRY
    |-> ##2 stack_bus.valid [*5] ##1 !stack_bus.valid)
    else $error("entry byte count wrong");
  return_done_a: assert property (
    !busy && op == CFS_OP_IRQ_RETURN |-> ##[1:8] ctx_valid)
    else $error("return never completes");
  level3_off_a: assert property (irq_disabled ==
    (condition_flags[CF_PHIGH] && condition_flags[CF_PLOW]))
    else $error("disable flag mismatch");
  push_c: cover property (!busy && op == CFS_OP_PUSH);
  entry_c: cover property (!busy && op == CFS_OP_IRQ_ENTRY);
  ret_c: cover property (ctx_valid);
endmodule : cfs_core_props

bind cfs_core cfs_core_props i_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .op(op), .alu(alu), .wr_data(wr_data), .ctx(ctx),
  .condition_flags(condition_flags), .stack_pointer(stack_pointer),
  .irq_disabled(irq_disabled), .stack_bus(stack_bus),
  .ctx_valid(ctx_valid), .busy(busy));

// File: cfs_core_tb.sv
`timescale 1ns/100ps
module cfs_core_tb;
  import cfs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  cfs_op_type op = CFS_OP_NONE;
  cfs_alu_type alu = '0;
  logic [7:0] wr_data = 8'h00;
  logic [1:0] src_priority = 2'b00;
  cfs_ctx_type ctx = '0;
  logic [7:0] condition_flags;
  logic [15:0] stack_pointer;
  logic [1:0] priority_level;
  logic irq_disabled;
  logic busy;
  logic ctx_valid;
  cfs_stack_type stack_bus;
  cfs_ctx_type ctx_restored;
  int n_errors = 0;
  int compares = 0;
  cfs_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .op(op), .alu(alu),
    .wr_data(wr_data), .src_priority(src_priority), .ctx(ctx),
    .condition_flags(condition_flags), .stack_pointer(stack_pointer),
    .priority_level(priority_level), .irq_disabled(irq_disabled),
    .stack_bus(stack_bus), .ctx_restored(ctx_restored),
    .ctx_valid(ctx_valid), .busy(busy));
  initial forever #2.5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  // sel 0 waits for idle, sel 1 for the return strobe
  task wait_hi(input int sel);
    for (int i = 0; i < 20; i++) begin
      if ((sel ? ctx_valid : !busy) === 1'b1) return;
      @(negedge clk_sys);
    end
    n_errors++;
    $display("mismatch at %0t: wait ran out", $time);
    summarize();
  endtask : wait_hi
  task run(input cfs_op_type o, input logic [7:0] d);
    @(negedge clk_sys);
    op = o;
    wr_data = d;
    @(negedge clk_sys);
    op = CFS_OP_NONE;
  endtask : run
  ////////////////////////////////////////////////////////////////////////
  task t_flags;
    logic [1:0] codes [4];
    codes = '{2'b10, 2'b01, 2'b00, 2'b11};
    check(condition_flags, 8'he8);
    check(irq_disabled, 1'b1);
    alu = '{8'h00, 1'b1, 1'b1, 1'b1, 1'b1};
    run(CFS_OP_ALU, 8'h00);
    check({condition_flags[4], condition_flags[2:0]}, 4'hb);
    alu = '{8'h80, 1'b0, 1'b0, 1'b1, 1'b1};
    run(CFS_OP_ALU, 8'h00);
    check({condition_flags[4], condition_flags[2:0]}, 4'h4);
    run(CFS_OP_SET_CARRY, 8'h00);
    check(condition_flags[CF_CARRY], 1'b1);
    run(CFS_OP_CLR_CARRY, 8'h00);
    check(condition_flags[CF_CARRY], 1'b0);
    alu = '{8'h00, 1'b1, 1'b0, 1'b0, 1'b0};
    run(CFS_OP_CARRY_ONLY, 8'h00);
    check(condition_flags[CF_CARRY], 1'b1);
    for (int i = 0; i < 4; i++) begin
      run(CFS_OP_PRIO_LOAD, {6'h00, codes[i]});
      check({condition_flags[5], condition_flags[3]}, codes[i]);
      check(priority_level, i);
      check(irq_disabled, i == 3);
    end
  endtask : t_flags
  task t_stack;
    run(CFS_OP_FLAGS_LOAD, 8'h15);
    check(condition_flags, 8'hd5);
    run(CFS_OP_SP_LOAD, 8'h00);
    check(stack_pointer, 16'h0100);
    run(CFS_OP_PUSH, 8'h00);
    check(stack_bus, {2'b11, 16'h0100, 8'hd5});
    check(stack_pointer, 16'h01ff);
    run(CFS_OP_POP, 8'h2a);
    check(stack_pointer, 16'h0100);
    check(condition_flags, 8'hea);
    run(CFS_OP_SP_RESET, 8'h00);
    check(stack_pointer, SP_RESET);
  endtask : t_stack
  task t_irq;
    logic [7:0] b [5];
    b = '{8'h11, 8'h22, 8'h33, 8'h44, 8'hea};
    ctx = '{8'h11, 8'h22, 8'h33, 8'h44};
    src_priority = 2'b01;
    run(CFS_OP_IRQ_ENTRY, 8'h00);
    for (int k = 0; k < 5; k++) begin
      @(negedge clk_sys);
      check(stack_bus, {2'b11, 16'h01ff - k[15:0], b[k]});
    end
    wait_hi(0);
    @(negedge clk_sys);
    check(stack_bus.valid, 1'b0);
    check(stack_pointer, 16'h01fa);
    check({condition_flags[5], condition_flags[3]}, 2'b01);
    b = '{8'h08, 8'h99, 8'h88, 8'h77, 8'h66};
    for (int k = 0; k < 6; k++) begin
      op = (k == 0) ? CFS_OP_IRQ_RETURN : CFS_OP_NONE;
      // pop data follows the byte read one cycle after the request
      wr_data = (k == 0) ? 8'h00 : b[k - 1];
      @(negedge clk_sys);
      if (k > 0) begin
        check(stack_bus[25:8], {2'b10, 16'h01fa + k[15:0]});
      end
    end
    op = CFS_OP_NONE;
    wait_hi(1);
    check(ctx_restored, 32'h66778899);
    check(condition_flags, 8'hc8);
    check(stack_pointer, 16'h01ff);
  endtask : t_irq
  task t_call;
    ctx = '{8'h12, 8'h34, 8'h00, 8'h00};
    run(CFS_OP_CALL, 8'h00);
    @(negedge clk_sys);
    check(stack_bus, {2'b11, 16'h01ff, 8'h12});
    @(negedge clk_sys);
    check(stack_bus, {2'b11, 16'h01fe, 8'h34});
    wait_hi(0);
    check(stack_pointer, 16'h01fd);
    run(CFS_OP_RETURN, 8'h12);
    wr_data = 8'h34;
    wait_hi(0);
    check(stack_pointer, 16'h01ff);
  endtask : t_call
  // reset in the middle of an interrupt entry
  task t_reset;
    run(CFS_OP_IRQ_ENTRY, 8'h00);
    @(negedge clk_sys);
    rst_n = 1'b0;
    @(negedge clk_sys);
    check(busy, 1'b0);
    check(stack_pointer, SP_RESET);
    check(condition_flags, CF_RESET);
    check(irq_disabled, 1'b1);
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    run(CFS_OP_PUSH, 8'h00);
    check(stack_bus, {2'b11, SP_RESET, CF_RESET});
    check(stack_pointer, 16'h01fe);
  endtask : t_reset
  initial begin
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    t_flags();
    t_stack();
    t_irq();
    t_call();
    t_reset();
    summarize();
  end
endmodule : cfs_core_tb
